// [verification/gpp_pin_model.sv]
`timescale 1ns/100ps

module gpp_pin_model #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic [W-1:0] out,
   input wire logic [W-1:0] oe_n,
   input wire logic [W-1:0] pu,
   input wire logic [W-1:0] en,
   input wire logic [W-1:0] val,
   output logic [W-1:0] lvl
);
   // A line nobody holds flips every cycle, so the synchroniser never takes it and a read returns the last level it took.
   logic [W-1:0] flt = '0;
   always_ff @(posedge clk) begin
      flt <= ~flt;
   end
   always_comb begin
      for (int i = 0; i < W; i++) begin
         if (!oe_n[i]) begin
            lvl[i] = out[i];
         end else if (en[i]) begin
            lvl[i] = val[i];
         end else if (pu[i]) begin
            lvl[i] = 1'b1;
         end else begin
            lvl[i] = flt[i];
         end
      end
   end
endmodule

// [verification/gpp_port_chk.sv]
`timescale 1ns/100ps

module gpp_port_chk
   import gpp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [GPP_ADDR_WIDTH-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic [GPP_B_WIDTH-1:0] second_port_pin_out,
   input wire logic [GPP_B_WIDTH-1:0] second_port_pin_oe_n,
   input wire logic [GPP_B_WIDTH-1:0] second_port_pullup_on,
   input wire logic [GPP_A_WIDTH-1:0] first_port_pin_oe_n
);
   // A request is taken only when the slave is neither acking nor resting.
   logic ack_d;
   logic tk;
   logic wtk;
   always_ff @(posedge sys_clk) begin
      ack_d <= rst ? 1'b0 : wb_ack_o;
   end
   assign tk = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~ack_d;
   assign wtk = tk & wb_we_i & wb_sel_i[0];
   default clocking cb @(posedge sys_clk); endclocking

   AST_RST_DIR: assert property (rst |=> second_port_pin_oe_n == 8'hFF && first_port_pin_oe_n == 6'h3F)
      else $error("direction not cleared by reset");
   AST_ACK_TAKE: assert property (disable iff (rst) tk |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack missing or too long");
   AST_ACK_CAUSE: assert property (disable iff (rst) $rose(wb_ack_o) |-> $past(tk))
      else $error("ack without request");
   AST_WR_B: assert property (disable iff (rst)
      wtk && wb_adr_i == GPP_OFS_B_DATA |=> second_port_pin_out == $past(wb_dat_i[7:0]))
      else $error("latch not loaded");
   AST_DIR_B: assert property (disable iff (rst)
      wtk && wb_adr_i == GPP_OFS_B_DIR |=> second_port_pin_oe_n == ~$past(wb_dat_i[7:0]))
      else $error("output enable wrong");
   AST_DIR_A: assert property (disable iff (rst)
      wtk && wb_adr_i == GPP_OFS_A_DIR |=> first_port_pin_oe_n == (~$past(wb_dat_i[5:0]) | 6'h04))
      else $error("first port enable wrong");
   AST_PU_OFF: assert property (disable iff (rst) (second_port_pullup_on & ~second_port_pin_oe_n) == 8'h00)
      else $error("pullup on a driven pin");
   AST_PU_CAUSE: assert property (disable iff (rst) $changed(second_port_pullup_on) |-> $past(wtk))
      else $error("pullup changed without write");
   AST_A2: assert property (disable iff (rst) first_port_pin_oe_n[2])
      else $error("input only pin driven");

   cover property (wtk && wb_adr_i == GPP_OFS_B_DIR);
   cover property (second_port_pullup_on != 8'h00);
   cover property (rst ##1 !rst);
endmodule

bind gpp_port gpp_port_chk u_chk (.*);

// [verification/gpp_port_tb.sv]
`timescale 1ns/100ps

module gpp_port_tb;
   import gpp_pkg::*;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic req = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wd = 32'h0;
   logic [3:0] sel = 4'h0;
   logic [31:0] rdat;
   logic [31:0] q;
   logic ack;
   logic [7:0] b_in, b_out, b_oen, b_pu;
   logic [5:0] a_in, a_out, a_oen, a_pu;
   logic [7:0] b_en = 8'h00;
   logic [7:0] b_val = 8'h00;
   logic [5:0] a_en = 6'h00;
   logic [5:0] a_val = 6'h00;
   int error_cnt = 0;
   int num_checks = 0;

   always #12.5 sys_clk = ~sys_clk;

   gpp_port dut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
      .second_port_pin_in(b_in), .second_port_pin_out(b_out), .second_port_pin_oe_n(b_oen),
      .second_port_pullup_on(b_pu), .first_port_pin_in(a_in), .first_port_pin_out(a_out),
      .first_port_pin_oe_n(a_oen), .first_port_pullup_on(a_pu));
   gpp_pin_model #(.W(8)) mb (.clk(sys_clk), .out(b_out), .oe_n(b_oen), .pu(b_pu),
      .en(b_en), .val(b_val), .lvl(b_in));
   gpp_pin_model #(.W(6)) ma (.clk(sys_clk), .out(a_out), .oe_n(a_oen), .pu(a_pu),
      .en(a_en), .val(a_val), .lvl(a_in));

   task automatic close_out();
      if (error_cnt == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
      int n;
      n = 0;
      req <= 1'b1;
      we <= w;
      adr <= a;
      wd <= {24'h0, d};
      sel <= s;
      do begin
         @(posedge sys_clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      req <= 1'b0;
      if (n >= 20) begin
         error_cnt++;
         close_out();
      end
      @(posedge sys_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wb(1'b1, a, d, 4'hF);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 8'h00, 4'hF);
      chk(q, exp);
   endtask

   task automatic t_reset();
      rdc(GPP_OFS_B_DIR, 32'h0);
      rdc(GPP_OFS_A_DIR, 32'h0);
      chk(b_oen, 8'hFF);
      chk(b_pu, 8'h00);
   endtask

   task automatic t_out_b();
      wr(GPP_OFS_B_DATA, 8'h3C);
      wr(GPP_OFS_B_DIR, 8'hFF);
      chk(b_out, 8'h3C);
      chk(b_oen, 8'h00);
      rdc(GPP_OFS_B_DATA, 32'h3C);
      wb(1'b1, GPP_OFS_B_DATA, 8'hC3, 4'hE);
      rdc(GPP_OFS_B_DATA, 32'h3C);
      rdc(8'h40, 32'h0);
   endtask

   task automatic t_in_b();
      wr(GPP_OFS_B_DIR, 8'h0F);
      b_en <= 8'hF0;
      b_val <= 8'hA5;
      wr(GPP_OFS_B_DATA, 8'h5A);
      repeat (5) @(posedge sys_clk);
      rdc(GPP_OFS_B_DATA, 32'hAA);
      chk(b_out, 8'h5A);
      b_en <= 8'h00;
      wr(GPP_OFS_B_DIR, 8'hFF);
      rdc(GPP_OFS_B_DATA, 32'h5A);
   endtask

   task automatic t_pu_b();
      wr(GPP_OFS_B_DIR, 8'h0F);
      wr(GPP_OFS_B_PUE, 8'hFF);
      chk(b_pu, 8'hF0);
      repeat (5) @(posedge sys_clk);
      rdc(GPP_OFS_B_DATA, 32'hFA);
      wr(GPP_OFS_B_PUE, 8'h00);
      chk(b_pu, 8'h00);
   endtask

   task automatic t_port_a();
      wr(GPP_OFS_A_PUE, 8'h3F);
      repeat (5) @(posedge sys_clk);
      rdc(GPP_OFS_A_DATA, 32'h3F);
      wr(GPP_OFS_A_DATA, 8'h2A);
      rdc(GPP_OFS_A_DATA, 32'h3F);
      chk(a_out, 6'h2A);
      a_en <= 6'h04;
      a_val <= 6'h04;
      wr(GPP_OFS_A_DIR, 8'h3F);
      chk(a_oen, 6'h04);
      chk(a_pu, 6'h00);
      repeat (5) @(posedge sys_clk);
      rdc(GPP_OFS_A_DATA, 32'h2E);
   endtask

   task automatic t_keep();
      rst <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      chk(b_out, 8'h5A);
      chk(b_oen, 8'hFF);
   endtask

   initial begin
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      t_reset();
      t_out_b();
      t_in_b();
      t_pu_b();
      t_port_a();
      t_keep();
      close_out();
   end
endmodule

// [verilog/gpp_pkg.sv]
package gpp_pkg;

   // ---------------------------------------------------------------
   // Port widths
   // ---------------------------------------------------------------
   localparam int GPP_B_WIDTH = 8;
   localparam int GPP_A_WIDTH = 6;
   localparam int GPP_PIN_WIDTH = GPP_B_WIDTH + GPP_A_WIDTH;
   localparam int GPP_A_INPUT_ONLY_BIT = 2;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] GPP_OFS_B_DATA = 8'h00;
   localparam logic [7:0] GPP_OFS_B_DIR = 8'h04;
   localparam logic [7:0] GPP_OFS_B_PUE = 8'h08;
   localparam logic [7:0] GPP_OFS_A_DATA = 8'h0C;
   localparam logic [7:0] GPP_OFS_A_DIR = 8'h10;
   localparam logic [7:0] GPP_OFS_A_PUE = 8'h14;
   localparam int GPP_ADDR_WIDTH = 8;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [GPP_B_WIDTH-1:0] GPP_B_DIR_RESET = 8'h00;
   localparam logic [GPP_B_WIDTH-1:0] GPP_B_PUE_RESET = 8'h00;
   localparam logic [GPP_A_WIDTH-1:0] GPP_A_DIR_RESET = 6'h00;
   localparam logic [GPP_A_WIDTH-1:0] GPP_A_PUE_RESET = 6'h00;
   localparam logic [31:0] GPP_READ_UNMAPPED = 32'h00000000;

   // ---------------------------------------------------------------
   // Bus slave states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      GPP_BUS_IDLE = 2'b00,
      GPP_BUS_ACK = 2'b01,
      GPP_BUS_DONE = 2'b11
   } gpp_bus_state_t;

endpackage

// [verilog/gpp_port.sv]
//
// Function
// R1 - Second port: eight pins, latch, direction, pullup
// R2 - Direction one drives pin, zero makes input
// R3 - Reset clears all second port direction bits
// R4 - Reset leaves data latches untouched
// R5 - Data read: latch if output, pin if input
// R6 - Data writes always load latch
// R7 - Pullup on when enabled and input
// R8 - Pullup disabled bit keeps pullup off
// R9 - Output direction forces pullup off immediately
// R10 - First port: same behaviour over six pins
// R11 - First port input writes touch only latch
// R12 - First port bit two never drives
// R13 - Software loads latch before making output
// R14 - Pin levels synchronised before register reads
//
// The Wishbone register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps

module gpp_port
   import gpp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [GPP_ADDR_WIDTH-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [GPP_B_WIDTH-1:0] second_port_pin_in,
   output logic [GPP_B_WIDTH-1:0] second_port_pin_out,
   output logic [GPP_B_WIDTH-1:0] second_port_pin_oe_n,
   output logic [GPP_B_WIDTH-1:0] second_port_pullup_on,
   input wire logic [GPP_A_WIDTH-1:0] first_port_pin_in,
   output logic [GPP_A_WIDTH-1:0] first_port_pin_out,
   output logic [GPP_A_WIDTH-1:0] first_port_pin_oe_n,
   output logic [GPP_A_WIDTH-1:0] first_port_pullup_on
);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Per bit read value: the latch where the pin is driven, the
   // synchronised pin level where it is an input.
   function automatic logic [GPP_B_WIDTH-1:0] port_read(
      input logic [GPP_B_WIDTH-1:0] latch,
      input logic [GPP_B_WIDTH-1:0] dir,
      input logic [GPP_B_WIDTH-1:0] pin
   );
      port_read = (latch & dir) | (pin & ~dir); // R5
   endfunction

   // The pullup follows the enable only while the pin is an input.
   function automatic logic [GPP_B_WIDTH-1:0] pullup_state(
      input logic [GPP_B_WIDTH-1:0] pue,
      input logic [GPP_B_WIDTH-1:0] dir
   );
      pullup_state = pue & ~dir; // R7 R8 R9
   endfunction

   // Byte lane zero carries every register of this block.
   function automatic logic lane0_write(
      input logic we,
      input logic [3:0] sel
   );
      lane0_write = we & sel[0];
   endfunction

   // Exact match on the full byte address, so unmapped words decode to nothing.
   function automatic logic addr_hit(
      input logic [GPP_ADDR_WIDTH-1:0] adr,
      input logic [GPP_ADDR_WIDTH-1:0] ofs
   );
      addr_hit = (adr == ofs);
   endfunction

   // Registers sit in the low bits of their word; the rest reads zero.
   function automatic logic [31:0] word_b(
      input logic [GPP_B_WIDTH-1:0] val
   );
      word_b = {{(32-GPP_B_WIDTH){1'b0}}, val};
   endfunction

   function automatic logic [31:0] word_a(
      input logic [GPP_A_WIDTH-1:0] val
   );
      word_a = {{(32-GPP_A_WIDTH){1'b0}}, val};
   endfunction

   // ---------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------
   logic [GPP_B_WIDTH-1:0] second_port_data_latch;
   logic [GPP_B_WIDTH-1:0] second_port_direction;
   logic [GPP_B_WIDTH-1:0] second_port_pullup_enable;
   logic [GPP_A_WIDTH-1:0] first_port_data_latch;
   logic [GPP_A_WIDTH-1:0] first_port_direction;
   logic [GPP_A_WIDTH-1:0] first_port_pullup_enable;

   gpp_bus_state_t bus_state;
   gpp_bus_state_t next_bus_state;

   logic bus_request;
   logic bus_take;
   logic bus_write;
   logic [7:0] wr_byte;

   logic sel_b_data;
   logic sel_b_dir;
   logic sel_b_pue;
   logic sel_a_data;
   logic sel_a_dir;
   logic sel_a_pue;
   logic wr_b_data;
   logic wr_b_dir;
   logic wr_b_pue;
   logic wr_a_data;
   logic wr_a_dir;
   logic wr_a_pue;

   logic [GPP_B_WIDTH-1:0] second_port_pin_bit;
   logic [GPP_A_WIDTH-1:0] first_port_pin_level;
   logic [GPP_A_WIDTH-1:0] first_port_drive;
   logic [GPP_B_WIDTH-1:0] a_read_wide;
   logic [GPP_A_WIDTH-1:0] a_read;
   logic [31:0] next_read;
   logic [31:0] rd_b_data;
   logic [31:0] rd_b_dir;
   logic [31:0] rd_b_pue;
   logic [31:0] rd_a_data;
   logic [31:0] rd_a_dir;
   logic [31:0] rd_a_pue;

   // ---------------------------------------------------------------
   // Pin synchronisation
   // ---------------------------------------------------------------
   gpp_sync_if pin_sync();

   assign pin_sync.raw = {first_port_pin_in, second_port_pin_in};

   gpp_sync u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .sync(pin_sync.filter)
   );

   assign second_port_pin_bit = pin_sync.clean[GPP_B_WIDTH-1:0]; // R14
   assign first_port_pin_level = pin_sync.clean[GPP_PIN_WIDTH-1:GPP_B_WIDTH]; // R14

   // ---------------------------------------------------------------
   // Bus slave sequencing
   // ---------------------------------------------------------------
   // The answer comes one cycle after the request and is dropped the
   // cycle after; the done state keeps a held request from being
   // answered twice while the master releases it.
   assign bus_request = wb_cyc_i & wb_stb_i;
   assign bus_take = (bus_state == GPP_BUS_IDLE) & bus_request;
   assign bus_write = bus_take & lane0_write(wb_we_i, wb_sel_i);
   assign wr_byte = wb_dat_i[7:0];

   always_comb begin
      case (bus_state)
         GPP_BUS_IDLE: begin
            next_bus_state = bus_request ? GPP_BUS_ACK : GPP_BUS_IDLE;
         end
         GPP_BUS_ACK: begin
            next_bus_state = GPP_BUS_DONE;
         end
         GPP_BUS_DONE: begin
            next_bus_state = GPP_BUS_IDLE;
         end
         default: begin
            next_bus_state = GPP_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         bus_state <= GPP_BUS_IDLE;
      end else begin
         bus_state <= next_bus_state;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_take;
      end
   end

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   assign sel_b_data = addr_hit(wb_adr_i, GPP_OFS_B_DATA);
   assign sel_b_dir = addr_hit(wb_adr_i, GPP_OFS_B_DIR);
   assign sel_b_pue = addr_hit(wb_adr_i, GPP_OFS_B_PUE);
   assign sel_a_data = addr_hit(wb_adr_i, GPP_OFS_A_DATA);
   assign sel_a_dir = addr_hit(wb_adr_i, GPP_OFS_A_DIR);
   assign sel_a_pue = addr_hit(wb_adr_i, GPP_OFS_A_PUE);

   // ---------------------------------------------------------------
   // Write strobes
   // ---------------------------------------------------------------
   // A strobe lasts only the taking edge, so a request held on through
   // the ack cycle can never write a register twice.
   assign wr_b_data = bus_write & sel_b_data;
   assign wr_b_dir = bus_write & sel_b_dir;
   assign wr_b_pue = bus_write & sel_b_pue;
   assign wr_a_data = bus_write & sel_a_data;
   assign wr_a_dir = bus_write & sel_a_dir;
   assign wr_a_pue = bus_write & sel_a_pue;

   // ---------------------------------------------------------------
   // Second port registers
   // ---------------------------------------------------------------
   // The latch has no reset on purpose: it keeps what it held, so
   // after power-up it is unknown until software writes it.
   always_ff @(posedge sys_clk) begin
      if (wr_b_data) begin
         second_port_data_latch <= wr_byte; // R1 R4 R6
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         second_port_direction <= GPP_B_DIR_RESET; // R3
      end else if (wr_b_dir) begin
         second_port_direction <= wr_byte; // R1 R2
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         second_port_pullup_enable <= GPP_B_PUE_RESET;
      end else if (wr_b_pue) begin
         second_port_pullup_enable <= wr_byte; // R1
      end
   end

   // ---------------------------------------------------------------
   // First port registers
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (wr_a_data) begin
         first_port_data_latch <= wr_byte[GPP_A_WIDTH-1:0]; // R4 R10 R11
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         first_port_direction <= GPP_A_DIR_RESET;
      end else if (wr_a_dir) begin
         first_port_direction <= wr_byte[GPP_A_WIDTH-1:0]; // R10
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         first_port_pullup_enable <= GPP_A_PUE_RESET;
      end else if (wr_a_pue) begin
         first_port_pullup_enable <= wr_byte[GPP_A_WIDTH-1:0]; // R10
      end
   end

   // ---------------------------------------------------------------
   // Pin drive
   // ---------------------------------------------------------------
   // Glitch-free enabling relies on software loading the latch before
   // it sets a direction bit; the drive itself is not delayed.
   assign second_port_pin_out = second_port_data_latch;
   assign second_port_pin_oe_n = ~second_port_direction; // R2
   assign second_port_pullup_on = pullup_state(second_port_pullup_enable, second_port_direction);

   always_comb begin
      first_port_drive = first_port_direction;
      first_port_drive[GPP_A_INPUT_ONLY_BIT] = 1'b0; // R12
   end

   assign first_port_pin_out = first_port_data_latch;
   assign first_port_pin_oe_n = ~first_port_drive; // R10 R12
   assign first_port_pullup_on = GPP_A_WIDTH'(pullup_state(
      {{(GPP_B_WIDTH-GPP_A_WIDTH){1'b0}}, first_port_pullup_enable},
      {{(GPP_B_WIDTH-GPP_A_WIDTH){1'b0}}, first_port_direction})); // R10

   // ---------------------------------------------------------------
   // Read back
   // ---------------------------------------------------------------
   // The input-only bit has no output path, so it always reports the
   // pin, even when its direction bit is set.
   assign a_read_wide = port_read(
      {{(GPP_B_WIDTH-GPP_A_WIDTH){1'b0}}, first_port_data_latch},
      {{(GPP_B_WIDTH-GPP_A_WIDTH){1'b0}}, first_port_drive},
      {{(GPP_B_WIDTH-GPP_A_WIDTH){1'b0}}, first_port_pin_level}); // R10 R11 R12
   assign a_read = a_read_wide[GPP_A_WIDTH-1:0];

   assign rd_b_data = word_b(port_read(second_port_data_latch, second_port_direction,
      second_port_pin_bit)); // R5 R6
   assign rd_b_dir = word_b(second_port_direction);
   assign rd_b_pue = word_b(second_port_pullup_enable);
   assign rd_a_data = word_a(a_read); // R10
   assign rd_a_dir = word_a(first_port_direction);
   assign rd_a_pue = word_a(first_port_pullup_enable);

   always_comb begin
      case (wb_adr_i)
         GPP_OFS_B_DATA: begin
            next_read = rd_b_data;
         end
         GPP_OFS_B_DIR: begin
            next_read = rd_b_dir;
         end
         GPP_OFS_B_PUE: begin
            next_read = rd_b_pue;
         end
         GPP_OFS_A_DATA: begin
            next_read = rd_a_data;
         end
         GPP_OFS_A_DIR: begin
            next_read = rd_a_dir;
         end
         GPP_OFS_A_PUE: begin
            next_read = rd_a_pue;
         end
         default: begin
            next_read = GPP_READ_UNMAPPED;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wb_dat_o <= GPP_READ_UNMAPPED;
      end else if (bus_take) begin
         wb_dat_o <= next_read;
      end
   end

endmodule

// [verilog/gpp_sync.sv]
`timescale 1ns/100ps

module gpp_sync
   import gpp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   gpp_sync_if.filter sync
);

   // ---------------------------------------------------------------
   // Three stage synchroniser
   // ---------------------------------------------------------------
   // The first stage is seen only by the second one, so a metastable
   // sample never reaches the agreement check or the register file.
   logic [GPP_PIN_WIDTH-1:0] stage1;
   logic [GPP_PIN_WIDTH-1:0] stage2;
   logic [GPP_PIN_WIDTH-1:0] stage3;
   logic [GPP_PIN_WIDTH-1:0] level;

   always_ff @(posedge sys_clk) begin
      stage1 <= sync.raw;
      stage2 <= stage1;
      stage3 <= stage2;
   end

   // A change is taken once the second and third stages agree.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         level <= '0;
      end else begin
         for (int i = 0; i < GPP_PIN_WIDTH; i++) begin
            if (stage2[i] == stage3[i]) begin
               level[i] <= stage3[i]; // R14
            end
         end
      end
   end

   assign sync.clean = level;

endmodule

// [verilog/gpp_sync_if.sv]
`timescale 1ns/100ps

interface gpp_sync_if;
   import gpp_pkg::*;

   logic [GPP_PIN_WIDTH-1:0] raw;
   logic [GPP_PIN_WIDTH-1:0] clean;

   modport producer (output raw, input clean);
   modport filter (input raw, output clean);
endinterface
